//--- accel_motion_event_logic.sv
// accelerometer core: trim load, sample output, self-test, motion events
// Operation
// - pulse new-sample flag whenever a fresh three-axis result is ready
// - wake and free-fall events consider only the enabled axes
// - copy gain and offset trims from storage at power-up before use
// - orientation interrupt once stable in one of six directions
// - all axes below free-fall threshold set flag and interrupt
// - output inside band for set time: sleep flag, interrupt, low power
// - output above threshold for set time: wake flag, interrupt, normal
// - threshold and windows recognise single and double clicks, flag each
// - outputs are two's complement, zero g coded as all zeros
// - self-test force applied only while the self-test bit is one
// - self-test output is real plus test response, scaled by full scale
`timescale 1ns/100ps
`default_nettype none
module accel_motion_event_logic
(
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic clk_en,
	input wire logic trim_rd_data_valid,
	input wire logic [11:0] trim_rd_data,
	output logic trim_rd_req,
	output logic [2:0] trim_rd_addr,
	output logic trim_done,
	input wire logic raw_valid,
	input wire logic signed [11:0] raw_x,
	input wire logic signed [11:0] raw_y,
	input wire logic signed [11:0] raw_z,
	input wire logic [1:0] full_scale,
	input wire logic self_test_en,
	input wire logic [2:0] axis_en,
	input wire logic [11:0] ff_threshold,
	input wire logic [7:0] ff_duration,
	input wire logic [11:0] wake_threshold,
	input wire logic [7:0] wake_duration,
	input wire logic [7:0] sleep_duration,
	input wire logic [11:0] orient_threshold,
	input wire logic [7:0] orient_duration,
	input wire logic [11:0] click_threshold,
	input wire logic [7:0] click_limit,
	input wire logic [7:0] click_latency,
	input wire logic [7:0] click_window,
	input wire logic status_clear,
	output logic self_test_drive,
	output logic signed [11:0] out_x,
	output logic signed [11:0] out_y,
	output logic signed [11:0] out_z,
	output logic new_sample,
	output logic ff_flag,
	output logic sleep_flag,
	output logic wake_flag,
	output logic orient_flag,
	output logic [5:0] orient_dir,
	output logic single_click_flag,
	output logic double_click_flag,
	output logic low_power,
	output logic event_irq
);
	// ****************************************
	// trim load
	// ****************************************
	typedef enum logic [2:0]
	{
		TR_REQ = 3'b001,
		TR_WAIT = 3'b010,
		TR_DONE = 3'b100
	} trim_state_e;
	trim_state_e trim_state;
	logic [11:0] trim_mem [0:5];
	logic [2:0] trim_idx;
	wire trim_last = (trim_idx == 3'(accel_motion_pkg::TRIM_WORDS - 1));
	assign trim_rd_req = (trim_state == TR_REQ);
	assign trim_rd_addr = trim_idx;
	assign trim_done = (trim_state == TR_DONE);
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			trim_state <= TR_REQ;
			trim_idx <= 3'h0;
		end
		else if (clk_en)
		begin
			unique case (trim_state)
				TR_REQ: trim_state <= TR_WAIT;
				TR_WAIT:
					if (trim_rd_data_valid)
					begin
						trim_idx <= trim_idx + 3'h1;
						trim_state <= trim_last ? TR_DONE : TR_REQ;
					end
				TR_DONE: trim_state <= TR_DONE;
				default: trim_state <= TR_REQ;
			endcase
		end
	end
	genvar gi;
	generate
		for (gi = 0; gi < 6; gi++)
		begin : g_trim
			always_ff @(posedge core_clk or negedge rst_b)
			begin
				if (!rst_b)
					trim_mem[gi] <= (gi < 3) ? accel_motion_pkg::GAIN_UNITY : 12'h000;
				else if (clk_en && trim_state == TR_WAIT && trim_rd_data_valid
					&& trim_idx == 3'(gi))
					trim_mem[gi] <= trim_rd_data;
			end
		end
	endgenerate

	// ****************************************
	// sample path
	// ****************************************
	// gain words 0..2, offset words 3..5; self-test force shifts by full-scale step
	function automatic logic signed [11:0] corr
	(
		input logic signed [11:0] raw,
		input logic [11:0] gain,
		input logic [11:0] offs,
		input logic [11:0] st,
		input logic st_on,
		input logic [1:0] fs
	);
		logic signed [25:0] prod;
		logic signed [13:0] stv;
		logic signed [25:0] sum;
		// widen both operands first so the product is never cut to 13 bits
		prod = 26'(raw) * 26'($signed({1'b0, gain}));
		stv = st_on ? 14'($signed({2'b00, st}) >>> fs) : 14'sh0;
		sum = (prod >>> accel_motion_pkg::GAIN_FRAC) - 26'($signed(offs))
			+ 26'(stv);
		if (sum > 26'sh7FF)
			corr = 12'sh7FF;
		else if (sum < -26'sh800)
			corr = -12'sh800;
		else
			corr = sum[11:0];
	endfunction
	function automatic logic [11:0] mag(input logic signed [11:0] v);
		mag = v[11] ? 12'(-v) : v;
	endfunction
	assign self_test_drive = self_test_en;
	wire use_sample = raw_valid && trim_done;
	wire signed [11:0] c_x = corr(raw_x, trim_mem[0], trim_mem[3],
		accel_motion_pkg::ST_FORCE_X, self_test_en, full_scale);
	wire signed [11:0] c_y = corr(raw_y, trim_mem[1], trim_mem[4],
		accel_motion_pkg::ST_FORCE_Y, self_test_en, full_scale);
	wire signed [11:0] c_z = corr(raw_z, trim_mem[2], trim_mem[5],
		accel_motion_pkg::ST_FORCE_Z, self_test_en, full_scale);
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			out_x <= accel_motion_pkg::ZERO_G_CODE;
			out_y <= accel_motion_pkg::ZERO_G_CODE;
			out_z <= accel_motion_pkg::ZERO_G_CODE;
			new_sample <= 1'b0;
		end
		else if (clk_en)
		begin
			new_sample <= use_sample;
			if (use_sample)
			begin
				out_x <= c_x;
				out_y <= c_y;
				out_z <= c_z;
			end
		end
	end

	// ****************************************
	// event detectors, run on new_sample
	// ****************************************
	wire [11:0] m_x = mag(out_x);
	wire [11:0] m_y = mag(out_y);
	wire [11:0] m_z = mag(out_z);
	wire eval = new_sample && clk_en;
	wire ff_cond = (!axis_en[0] || m_x < ff_threshold)
		&& (!axis_en[1] || m_y < ff_threshold)
		&& (!axis_en[2] || m_z < ff_threshold) && (axis_en != 3'h0);
	wire wake_cond = (axis_en[0] && m_x > wake_threshold)
		|| (axis_en[1] && m_y > wake_threshold)
		|| (axis_en[2] && m_z > wake_threshold);
	wire [5:0] dir_now = {out_z[11] && m_z > orient_threshold,
		!out_z[11] && m_z > orient_threshold,
		out_y[11] && m_y > orient_threshold,
		!out_y[11] && m_y > orient_threshold,
		out_x[11] && m_x > orient_threshold,
		!out_x[11] && m_x > orient_threshold};
	wire dir_one = (dir_now != 6'h00) && ((dir_now & (dir_now - 6'h01)) == 6'h00);
	wire click_cond = (m_x > click_threshold) || (m_y > click_threshold)
		|| (m_z > click_threshold);
	logic [7:0] ff_cnt, wake_cnt, sleep_cnt, orient_cnt, click_cnt, gap_cnt;
	logic [5:0] dir_prev;
	logic click_hi, click_armed;
	wire ff_hit = eval && ff_cond && ff_cnt >= ff_duration;
	wire wake_hit = eval && wake_cond && low_power
		&& wake_cnt >= wake_duration;
	wire sleep_hit = eval && !wake_cond && !low_power
		&& sleep_cnt >= sleep_duration;
	wire orient_hit = eval && dir_one && dir_now == dir_prev
		&& orient_cnt == orient_duration && dir_now != orient_dir;
	wire click_rel = eval && !click_cond && click_hi
		&& click_cnt <= click_limit;
	wire dbl_hit = click_rel && click_armed
		&& gap_cnt >= click_latency;
	wire sgl_hit = click_rel && !dbl_hit;
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			ff_cnt <= 8'h00;
			wake_cnt <= 8'h00;
			sleep_cnt <= 8'h00;
			orient_cnt <= 8'h00;
			dir_prev <= 6'h00;
			low_power <= 1'b0;
		end
		else if (eval)
		begin
			ff_cnt <= ff_cond ? (ff_cnt == 8'hFF ? ff_cnt : ff_cnt + 8'h01) : 8'h00;
			wake_cnt <= wake_cond ? (wake_cnt == 8'hFF ? wake_cnt : wake_cnt + 8'h01)
				: 8'h00;
			sleep_cnt <= (!wake_cond && !low_power)
				? (sleep_cnt == 8'hFF ? sleep_cnt : sleep_cnt + 8'h01) : 8'h00;
			dir_prev <= dir_now;
			orient_cnt <= (dir_one && dir_now == dir_prev)
				? (orient_cnt == orient_duration ? orient_cnt : orient_cnt + 8'h01)
				: 8'h00;
			if (sleep_hit)
				low_power <= 1'b1;
			else if (wake_hit)
				low_power <= 1'b0;
		end
	end
	// click: window opens after a short peak, closes after latency+window
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			click_hi <= 1'b0;
			click_cnt <= 8'h00;
			click_armed <= 1'b0;
			gap_cnt <= 8'h00;
		end
		else if (eval)
		begin
			click_hi <= click_cond;
			click_cnt <= click_cond ? (click_cnt == 8'hFF ? click_cnt
				: click_cnt + 8'h01) : 8'h00;
			if (dbl_hit)
				click_armed <= 1'b0;
			else if (sgl_hit)
			begin
				click_armed <= 1'b1;
				gap_cnt <= 8'h00;
			end
			else if (click_armed)
			begin
				gap_cnt <= gap_cnt + 8'h01;
				if (9'(gap_cnt) >= 9'(click_latency) + 9'(click_window))
					click_armed <= 1'b0;
			end
		end
	end

	// ****************************************
	// sticky status, set beats clear
	// ****************************************
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			ff_flag <= 1'b0;
			sleep_flag <= 1'b0;
			wake_flag <= 1'b0;
			orient_flag <= 1'b0;
			orient_dir <= 6'h00;
			single_click_flag <= 1'b0;
			double_click_flag <= 1'b0;
		end
		else if (clk_en)
		begin
			ff_flag <= ff_hit || (ff_flag && !status_clear);
			sleep_flag <= sleep_hit || (sleep_flag && !status_clear);
			wake_flag <= wake_hit || (wake_flag && !status_clear);
			orient_flag <= orient_hit || (orient_flag && !status_clear);
			single_click_flag <= sgl_hit || (single_click_flag && !status_clear);
			double_click_flag <= dbl_hit || (double_click_flag && !status_clear);
			if (orient_hit)
				orient_dir <= dir_now;
		end
	end
	assign event_irq = ff_flag || sleep_flag || wake_flag || orient_flag
		|| single_click_flag || double_click_flag;

	a_sample_strobe: assert property (@(posedge core_clk) disable iff (!rst_b)
		(clk_en && raw_valid && trim_done) |=> new_sample)
		else $error("new sample not flagged");
	a_no_early_use: assert property (@(posedge core_clk) disable iff (!rst_b)
		new_sample |-> $past(trim_done))
		else $error("sample used before trims loaded");
	a_ff_flag_set: assert property (@(posedge core_clk) disable iff (!rst_b)
		(clk_en && ff_hit) |=> ff_flag && event_irq)
		else $error("free-fall flag missing");
	a_sleep_lp: assert property (@(posedge core_clk) disable iff (!rst_b)
		(clk_en && sleep_hit) |=> sleep_flag && low_power)
		else $error("sleep did not enter low power");
	a_wake_normal: assert property (@(posedge core_clk) disable iff (!rst_b)
		(clk_en && wake_hit) |=> wake_flag && !low_power)
		else $error("wake did not restore normal");
	a_click_flag: assert property (@(posedge core_clk) disable iff (!rst_b)
		(clk_en && (sgl_hit || dbl_hit)) |=> (single_click_flag
		|| double_click_flag))
		else $error("click flag missing");
	a_orient_one: assert property (@(posedge core_clk) disable iff (!rst_b)
		orient_hit |=> orient_flag && orient_dir == $past(dir_now)
		&& $onehot(orient_dir))
		else $error("orientation direction not latched");
	a_st_follow: assert property (@(posedge core_clk) disable iff (!rst_b)
		self_test_drive == self_test_en)
		else $error("self-test drive mismatch");
	a_ff_axes: assert property (@(posedge core_clk) disable iff (!rst_b)
		ff_hit |-> axis_en != 3'h0)
		else $error("free-fall with no axis enabled");
endmodule // accel_motion_event_logic
`default_nettype wire

//--- accel_motion_pkg.sv
// constants shared by the accelerometer digital core
package accel_motion_pkg;
	localparam int SAMPLE_W = 12;
	localparam int TRIM_W = 12;
	localparam int DUR_W = 8;
	localparam int NUM_AXES = 3;
	localparam int TRIM_WORDS = 6;
	localparam logic [2:0] TRIM_ADDR_W = 3'h3;
	localparam logic [SAMPLE_W-1:0] ZERO_G_CODE = 12'h000;
	localparam logic [TRIM_W-1:0] GAIN_UNITY = 12'h400;
	localparam int GAIN_FRAC = 10;
	localparam logic [1:0] FS_2G = 2'h0;
	localparam logic [1:0] FS_4G = 2'h1;
	localparam logic [1:0] FS_8G = 2'h2;
	localparam logic [1:0] FS_16G = 2'h3;
	localparam logic [SAMPLE_W-1:0] ST_FORCE_X = 12'h114;
	localparam logic [SAMPLE_W-1:0] ST_FORCE_Y = 12'h114;
	localparam logic [SAMPLE_W-1:0] ST_FORCE_Z = 12'h3D8;
	localparam int ORIENT_XP = 0;
	localparam int ORIENT_XN = 1;
	localparam int ORIENT_YP = 2;
	localparam int ORIENT_YN = 3;
	localparam int ORIENT_ZP = 4;
	localparam int ORIENT_ZN = 5;
	localparam logic [DUR_W-1:0] DUR_ZERO = 8'h00;
endpackage

//--- tb.sv
// bench for the accelerometer core: trim load, samples, self-test, events
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin \
	bad_count++; $display("unexpected %s exp %0h got %0h", n, e, g); end end
module tb;
	logic core_clk = 1'b0, rst_b = 1'b0, clk_en = 1'b1, raw_valid = 1'b0;
	logic trim_rd_data_valid, trim_rd_req, trim_done;
	logic [11:0] trim_rd_data;
	logic [2:0] trim_rd_addr;
	logic signed [11:0] raw_x = 12'h000, raw_y = 12'h000, raw_z = 12'h000;
	logic signed [11:0] out_x, out_y, out_z;
	logic [1:0] full_scale = 2'h0;
	logic self_test_en = 1'b0, status_clear = 1'b0;
	logic [2:0] axis_en = 3'h7;
	logic [11:0] ff_threshold = 12'h032, wake_threshold = 12'h12C;
	logic [11:0] orient_threshold = 12'h320, click_threshold = 12'h5DC;
	logic [7:0] ff_duration = 8'h02, wake_duration = 8'h01;
	logic [7:0] sleep_duration = 8'h03, orient_duration = 8'h02;
	logic [7:0] click_limit = 8'h02, click_latency = 8'h02;
	logic [7:0] click_window = 8'h04;
	logic self_test_drive, new_sample, ff_flag, sleep_flag, wake_flag;
	logic orient_flag, single_click_flag, double_click_flag, low_power;
	logic event_irq;
	logic [5:0] orient_dir;
	int bad_count = 0, comparisons = 0, cycles = 0;
	accel_motion_event_logic u_dut (.core_clk, .rst_b, .clk_en,
		.trim_rd_data_valid, .trim_rd_data, .trim_rd_req, .trim_rd_addr,
		.trim_done, .raw_valid, .raw_x, .raw_y, .raw_z, .full_scale,
		.self_test_en, .axis_en, .ff_threshold, .ff_duration,
		.wake_threshold, .wake_duration, .sleep_duration,
		.orient_threshold, .orient_duration, .click_threshold,
		.click_limit, .click_latency, .click_window, .status_clear,
		.self_test_drive, .out_x, .out_y, .out_z, .new_sample, .ff_flag,
		.sleep_flag, .wake_flag, .orient_flag, .orient_dir,
		.single_click_flag, .double_click_flag, .low_power, .event_irq);
	trim_store u_store (.core_clk, .rst_b, .trim_rd_req, .trim_rd_addr,
		.trim_rd_data_valid, .trim_rd_data);
	always #12.5 core_clk = ~core_clk;
	task automatic finish_test();
		$display("checks %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// hang guard, well above the few hundred cycles the run needs
	always @(posedge core_clk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			bad_count++;
			finish_test();
		end
	end
	task automatic send(input logic [11:0] x, y, z, input int n);
		repeat (n)
		begin
			@(posedge core_clk);
			#2 raw_valid = 1'b1;
			raw_x = x;
			raw_y = y;
			raw_z = z;
			@(posedge core_clk);
			#2 raw_valid = 1'b0;
			`CHK("new_sample", 1'b1, new_sample)
		end
		@(posedge core_clk);
		#2;
	endtask
	task automatic clear();
		status_clear = 1'b1;
		@(posedge core_clk);
		#2 status_clear = 1'b0;
		`CHK("irq cleared", 1'b0, event_irq)
	endtask
	// +z was already latched by the free-fall run, so start from -z
	logic [11:0] oz[3] = '{12'hC18, 12'h3E8, 12'h000};
	logic [11:0] ox[3] = '{12'h000, 12'h000, 12'hE0C};
	logic [5:0] od[3] = '{6'h20, 6'h10, 6'h02};
	initial
	begin
		repeat (2) @(posedge core_clk);
		`CHK("req at reset", 1'b1, trim_rd_req)
		`CHK("out at reset", 12'h000, out_x)
		#2 rst_b = 1'b1;
		raw_valid = 1'b1;
		@(posedge core_clk);
		#2 raw_valid = 1'b0;
		`CHK("early sample", 1'b0, new_sample)
		repeat (100) if (trim_done !== 1'b1) @(posedge core_clk);
		#2 `CHK("trim_done", 1'b1, trim_done)
		clk_en = 1'b0;
		raw_valid = 1'b1;
		@(posedge core_clk);
		#2 raw_valid = 1'b0;
		clk_en = 1'b1;
		`CHK("frozen sample", 1'b0, new_sample)
		send(12'h064, 12'h064, 12'hFF9, 1);
		`CHK("gain x", 12'h0C8, out_x)
		`CHK("offset y", 12'h05F, out_y)
		`CHK("neg z", 12'hFF9, out_z)
		send(12'h000, 12'h005, 12'h000, 1);
		`CHK("zero g", 12'h000, out_y)
		clear();
		axis_en = 3'h3;
		send(12'h000, 12'h005, 12'h3E8, 1);
		`CHK("ff early", 1'b0, ff_flag)
		send(12'h000, 12'h005, 12'h3E8, 5);
		`CHK("ff masked z", 1'b1, ff_flag)
		`CHK("ff irq", 1'b1, event_irq)
		axis_en = 3'h7;
		clear();
		// masked free-fall run already slept, so wake comes first
		send(12'h0C8, 12'h005, 12'h000, 4);
		`CHK("wake", 1'b1, wake_flag)
		`CHK("normal", 1'b0, low_power)
		send(12'h000, 12'h005, 12'h000, 6);
		`CHK("sleep", 1'b1, sleep_flag)
		`CHK("low power", 1'b1, low_power)
		clear();
		for (int i = 0; i < 3; i++)
		begin
			send(ox[i], 12'h005, oz[i], 5);
			`CHK("orient flag", 1'b1, orient_flag)
			`CHK("orient dir", od[i], orient_dir)
		end
		clear();
		send(12'h000, 12'h005, 12'h708, 1);
		send(12'h000, 12'h005, 12'h000, 8);
		`CHK("single", 1'b1, single_click_flag)
		`CHK("no double", 1'b0, double_click_flag)
		clear();
		send(12'h000, 12'h005, 12'h708, 1);
		send(12'h000, 12'h005, 12'h000, 2);
		send(12'h000, 12'h005, 12'h708, 1);
		send(12'h000, 12'h005, 12'h000, 8);
		`CHK("double", 1'b1, double_click_flag)
		self_test_en = 1'b1;
		#1 `CHK("st drive", 1'b1, self_test_drive)
		for (int fs = 0; fs < 4; fs++)
		begin
			full_scale = fs[1:0];
			send(12'h000, 12'h005, 12'h000, 1);
			`CHK("st z", 12'(984 >> fs), out_z)
			`CHK("st x", 12'(276 >> fs), out_x)
		end
		full_scale = 2'h0;
		send(12'h000, 12'h005, 12'h064, 1);
		`CHK("st sum", 12'h43C, out_z)
		self_test_en = 1'b0;
		send(12'h000, 12'h005, 12'h000, 1);
		`CHK("st off", 12'h000, out_z)
		`CHK("st undrive", 1'b0, self_test_drive)
		// second power-up must fetch the trims again
		rst_b = 1'b0;
		@(posedge core_clk);
		#2 rst_b = 1'b1;
		`CHK("reload start", 1'b0, trim_done)
		repeat (100) if (trim_done !== 1'b1) @(posedge core_clk);
		#2 `CHK("reload done", 1'b1, trim_done)
		send(12'h064, 12'h064, 12'hFF9, 1);
		`CHK("reload gain", 12'h0C8, out_x)
		`CHK("reload offset", 12'h05F, out_y)
		finish_test();
	end
endmodule // tb
`default_nettype wire

//--- trim_store.sv
// trim storage model answering the core's power-up trim reads
`timescale 1ns/100ps
`default_nettype none
module trim_store
(
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic trim_rd_req,
	input wire logic [2:0] trim_rd_addr,
	output logic trim_rd_data_valid,
	output logic [11:0] trim_rd_data
);
	logic [2:0] addr;
	logic [2:0] wait_cnt;
	logic busy;
	logic [11:0] word;
	// gain x doubled, offset y 5, others neutral
	always_comb
	begin
		case (addr)
			3'h0: word = 12'h800;
			3'h3, 3'h5: word = 12'h000;
			3'h4: word = 12'h005;
			default: word = 12'h400;
		endcase
	end
	// later words answer slower; data is garbage outside the valid pulse
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			busy <= 1'b0;
			addr <= 3'h0;
			wait_cnt <= 3'h0;
			trim_rd_data_valid <= 1'b0;
			trim_rd_data <= 12'hA5A;
		end
		else if (trim_rd_req && !busy)
		begin
			busy <= 1'b1;
			addr <= trim_rd_addr;
			wait_cnt <= trim_rd_addr;
			trim_rd_data_valid <= 1'b0;
			trim_rd_data <= ~trim_rd_data;
		end
		else if (busy && wait_cnt == 3'h0)
		begin
			busy <= 1'b0;
			trim_rd_data_valid <= 1'b1;
			trim_rd_data <= word;
		end
		else
		begin
			wait_cnt <= wait_cnt - 3'h1;
			trim_rd_data_valid <= 1'b0;
			trim_rd_data <= ~trim_rd_data;
		end
	end
endmodule // trim_store
`default_nettype wire
